// file: rtl/register_preload_and_read_lock.sv
// test access: read-lock fuse readback and register preload for all output cells
`timescale 1ns/1ns
`default_nettype none
module register_preload_and_read_lock
  import preload_pkg::*;
#(
  parameter int CELLS = NUM_CELLS
)(
  input wire logic clock,
  input wire logic resetn,
  input wire logic hv_entry,
  input wire logic clock_term,
  input wire logic select_pin,
  input wire logic [CELLS-1:0] io_in,
  input wire logic [CELLS-1:0] sum_term0,
  input wire logic [CELLS-1:0] sum_term1,
  input wire logic [CELLS-1:0] polarity,
  input wire logic [CELLS-1:0] oe_term,
  output logic [CELLS-1:0] io_out,
  output logic [CELLS-1:0] io_oe,
  output logic [CELLS-1:0] feedback0,
  output logic [CELLS-1:0] feedback1,
  output logic preload_active,
  input wire logic verify_req,
  input wire logic fuse_bit,
  input wire logic lock_program,
  input wire logic lock_stored,
  output logic verify_valid,
  output logic verify_data,
  output logic lock_active
);
  import preload_pkg::*;

  // mode state
  mode_t mode_reg;
  mode_t mode_next;
  // clock term history for edge detection
  logic clock_term_reg;
  logic clock_term_next;
  logic load_pulse;
  // read-lock and verify state
  logic lock_reg;
  logic lock_next;
  logic verify_valid_reg;
  logic verify_valid_next;
  logic verify_data_reg;
  logic verify_data_next;
  // registered pin drive
  logic [CELLS-1:0] io_out_reg;
  logic [CELLS-1:0] io_out_next;
  logic [CELLS-1:0] q0;
  logic [CELLS-1:0] q1;

  // mode: preload only while the entry level stands
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      MODE_NORMAL: begin
        if (hv_entry) begin
          mode_next = MODE_PRELOAD;
        end
      end
      MODE_PRELOAD: begin
        // dropping the entry level ends preload at the next clock edge
        if (!hv_entry) begin
          mode_next = MODE_NORMAL;
        end
      end
      default: begin
        mode_next = MODE_NORMAL;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mode_reg <= MODE_NORMAL;
    end else begin
      mode_reg <= mode_next;
    end
  end

  assign preload_active = (mode_reg == MODE_PRELOAD);

  // rising edge of the clock term; pins are already synchronous
  always_comb begin
    clock_term_next = clock_term;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      clock_term_reg <= 1'h0;
    end else begin
      clock_term_reg <= clock_term_next;
    end
  end

  assign load_pulse = clock_term & ~clock_term_reg;

  // twenty registers as ten pairs
  for (genvar i = 0; i < CELLS; i++) begin : g_cell
    register_pair_cell u_cell (
      .clock(clock),
      .resetn(resetn),
      .preload(preload_active),
      .load_pulse(load_pulse),
      .select(select_pin),
      .force_level(io_in[i]),
      .sum0(sum_term0[i]),
      .sum1(sum_term1[i]),
      .q0(q0[i]),
      .q1(q1[i])
    );
  end

  assign feedback0 = q0;
  assign feedback1 = q1;

  // pin drive: first register through the polarity, one cycle behind
  always_comb begin
    io_out_next = q0 ^ polarity;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      io_out_reg <= '0;
    end else begin
      io_out_reg <= io_out_next;
    end
  end

  assign io_out = io_out_reg;
  // pins are released during preload so the tester can force them
  assign io_oe = preload_active ? '0 : oe_term;

  // read lock: sticky, set by programming or by the stored fuse
  always_comb begin
    lock_next = lock_reg | lock_program | lock_stored;
  end

  // verify answer uses the next lock value so programming acts at once
  always_comb begin
    verify_valid_next = verify_req;
    verify_data_next = verify_data_reg;
    if (verify_req) begin
      if (lock_next) begin
        verify_data_next = FUSE_PROGRAMMED;
      end else begin
        verify_data_next = fuse_bit;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      lock_reg <= LOCK_RESET_VALUE;
      verify_valid_reg <= 1'h0;
      verify_data_reg <= 1'h0;
    end else begin
      lock_reg <= lock_next;
      verify_valid_reg <= verify_valid_next;
      verify_data_reg <= verify_data_next;
    end
  end

  assign lock_active = lock_reg;
  assign verify_valid = verify_valid_reg;
  assign verify_data = verify_data_reg;

  // checks on the block's own outputs
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  a_lock_stays_set: assert property (lock_active |=> lock_active [*4])
    else $error("read lock cleared after being set");
  a_locked_reads_one: assert property (verify_req && lock_active |=>
      verify_valid && verify_data)
    else $error("locked device returned an unprogrammed fuse");
  a_lock_immediate: assert property (verify_req && lock_program |=>
      verify_data && lock_active)
    else $error("lock did not act on the same request");
  a_open_reads_fuse: assert property (verify_req && !lock_active && !lock_program
      && !lock_stored |=> verify_valid && verify_data == $past(fuse_bit))
    else $error("unlocked readback does not match fuse");
  a_preload_first: assert property (preload_active && load_pulse && !select_pin
      |=> feedback0 == $past(io_in) && feedback1 == $past(feedback1))
    else $error("select low preload wrong");
  a_preload_second: assert property (preload_active && load_pulse && select_pin
      |=> feedback1 == $past(io_in) && feedback0 == $past(feedback0))
    else $error("select high preload wrong");
  a_preload_polarity: assert property (preload_active && load_pulse && !select_pin
      |=> ##1 io_out == ($past(io_in, 2) ^ $past(polarity)))
    else $error("preloaded level not independent of polarity");
  a_preload_entry: assert property (hv_entry |=> preload_active)
    else $error("entry level did not enter preload");
  a_pins_released: assert property (preload_active |-> io_oe == '0)
    else $error("pins driven during preload");
  a_pins_follow_oe: assert property (!preload_active |-> io_oe == oe_term)
    else $error("pin enable differs from its term outside preload");
  a_hold_no_pulse: assert property (!load_pulse |=> feedback0 == $past(feedback0)
      && feedback1 == $past(feedback1))
    else $error("register changed without a clock term pulse");
  // a shared clock term outside preload must load both registers of every pair
  a_normal_load: assert property (!preload_active && load_pulse |=>
      feedback0 == $past(sum_term0) && feedback1 == $past(sum_term1))
    else $error("normal clock term did not load both sum terms");
  a_verify_pulse: assert property (!verify_req |=> !verify_valid)
    else $error("verify answer without a request");

  c_lock_set: cover property (!lock_active ##1 lock_active);
  c_normal_load: cover property (!preload_active && load_pulse);
  c_preload_first: cover property (preload_active && load_pulse && !select_pin);
  c_preload_second: cover property (preload_active && load_pulse && select_pin);
  c_verify_locked: cover property (verify_req && lock_active ##1 verify_valid);
endmodule
`default_nettype wire

// file: rtl/preload_pkg.sv
// constants and types shared by the preload and read-lock logic
package preload_pkg;
  // output cells in the device, each holding a pair of registers
  localparam int NUM_CELLS = 10;
  localparam int REGS_PER_CELL = 2;
  localparam int TOTAL_REGS = NUM_CELLS * REGS_PER_CELL;
  // register contents after reset
  localparam logic REG_RESET_VALUE = 1'h0;
  // read-lock state after reset, before the stored fuse is sampled
  localparam logic LOCK_RESET_VALUE = 1'h0;
  // level that a locked fuse reads back as
  localparam logic FUSE_PROGRAMMED = 1'h1;
  // select pin level that picks the first register of a pair
  localparam logic SELECT_FIRST = 1'h0;
  // clock period and cycles from verify request to answer
  localparam int CLOCK_PERIOD_NS = 4;
  localparam int VERIFY_LATENCY = 1;

  // operating mode, gray coded
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_PRELOAD = 2'h1
  } mode_t;
endpackage

// file: rtl/register_pair_cell.sv
// one output cell: two registers with clock-term load and preload forcing
`timescale 1ns/1ns
`default_nettype none
module register_pair_cell
  import preload_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic preload,
  input wire logic load_pulse,
  input wire logic select,
  input wire logic force_level,
  input wire logic sum0,
  input wire logic sum1,
  output logic q0,
  output logic q1
);
  logic q0_reg; // first register of the pair
  logic q1_reg; // second register of the pair
  logic q0_next;
  logic q1_next;

  // next state: preload forces the raw pin level, else sum terms load
  always_comb begin
    q0_next = q0_reg;
    q1_next = q1_reg;
    if (load_pulse) begin
      if (preload) begin
        // pin level goes in untouched, output polarity plays no part
        if (select == SELECT_FIRST) begin
          q0_next = force_level;
        end else begin
          q1_next = force_level;
        end
        // the unselected register simply keeps its value
      end else begin
        // normal clocking, both registers take their sum terms
        q0_next = sum0;
        q1_next = sum1;
      end
    end
  end

  // storage only
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      q0_reg <= REG_RESET_VALUE;
      q1_reg <= REG_RESET_VALUE;
    end else begin
      q0_reg <= q0_next;
      q1_reg <= q1_next;
    end
  end

  assign q0 = q0_reg;
  assign q1 = q1_reg;
endmodule
`default_nettype wire

// file: dv/preload_tester.sv
// behavioural tester model that drives the preload entry and pin levels
`timescale 1ns/1ns
`default_nettype none
module preload_tester (
  input wire logic clock,
  output logic hv_entry,
  output logic clock_term,
  output logic select_pin,
  output logic [9:0] io_in
);
  // idle pins before any frame
  initial begin
    hv_entry = 1'h0;
    clock_term = 1'h0;
    select_pin = 1'h0;
    io_in = 10'h000;
  end

  // one preload frame; entry level stays up until the load is over
  task automatic preload(input logic sel, input logic [9:0] lvl);
    @(posedge clock);
    #1 hv_entry = 1'h1;
    repeat (2) @(posedge clock);
    #1 select_pin = sel;
    io_in = lvl;
    clock_term = 1'h1;
    @(posedge clock);
    #1 clock_term = 1'h0; // low gap before any later pulse
    repeat (2) @(posedge clock);
    // released pins show the inverse, so a stale value cannot pass
    #1 io_in = ~lvl;
    select_pin = ~sel;
    hv_entry = 1'h0;
  endtask

  // one clock-term pulse with the entry level low, a normal load
  task automatic pulse_term();
    @(posedge clock);
    #1 clock_term = 1'h1;
    @(posedge clock);
    #1 clock_term = 1'h0;
    @(posedge clock);
    #1;
  endtask
endmodule
`default_nettype wire

// file: dv/tb_register_preload_and_read_lock.sv
// self-checking bench for the preload and read-lock logic
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module tb_register_preload_and_read_lock;
  import preload_pkg::*;
  logic clock = 1'h0; // bench clock
  logic resetn = 1'h0; // held low at start
  logic hv_entry, clock_term, select_pin; // from the tester model
  logic [9:0] io_in, io_out, io_oe, feedback0, feedback1;
  logic [9:0] polarity = 10'h000;
  // fixed terms tied to the block, also the expected normal-mode loads
  localparam logic [9:0] SUM0 = 10'h0F0;
  localparam logic [9:0] SUM1 = 10'h30C;
  localparam logic [9:0] OE_TERMS = 10'h3C3;
  logic verify_req = 1'h0, fuse_bit = 1'h0, lock_program = 1'h0, lock_stored = 1'h0;
  logic preload_active, verify_valid, verify_data, lock_active;
  logic [9:0] exp0 = {10{REG_RESET_VALUE}}, exp1 = {10{REG_RESET_VALUE}};
  int n_fail = 0;
  int cmp_count = 0;

  // clock generator
  always #(CLOCK_PERIOD_NS / 2) clock = ~clock;

  register_preload_and_read_lock #(.CELLS(10)) u_dut (
    .clock(clock), .resetn(resetn), .hv_entry(hv_entry), .clock_term(clock_term),
    .select_pin(select_pin), .io_in(io_in), .sum_term0(SUM0), .sum_term1(SUM1),
    .polarity(polarity), .oe_term(OE_TERMS), .io_out(io_out), .io_oe(io_oe),
    .feedback0(feedback0), .feedback1(feedback1), .preload_active(preload_active),
    .verify_req(verify_req), .fuse_bit(fuse_bit), .lock_program(lock_program),
    .lock_stored(lock_stored), .verify_valid(verify_valid), .verify_data(verify_data),
    .lock_active(lock_active)
  );

  preload_tester u_tester (
    .clock(clock), .hv_entry(hv_entry), .clock_term(clock_term),
    .select_pin(select_pin), .io_in(io_in)
  );

  // one preload frame, then both registers and the pin are judged
  task automatic load_one(input logic sel, input logic [9:0] lvl);
    u_tester.preload(sel, lvl);
    if (sel === SELECT_FIRST) exp0 = lvl;
    else exp1 = lvl;
    `CHK(feedback0, exp0)
    `CHK(feedback1, exp1)
    `CHK(io_out, exp0 ^ polarity)
    `CHK(io_oe, 10'h000)
    `CHK(preload_active, 1'h1)
  endtask

  // a clock-term pulse outside preload loads both sum terms
  task automatic test_normal_load();
    u_tester.pulse_term();
    exp0 = SUM0;
    exp1 = SUM1;
    `CHK(feedback0, exp0)
    `CHK(feedback1, exp1)
    `CHK(io_out, exp0 ^ polarity)
    `CHK(io_oe, OE_TERMS)
    `CHK(preload_active, 1'h0)
  endtask

  // all ones, all zeros and a mix into both registers, both polarities
  task automatic test_preload();
    logic [9:0] pats [3] = '{10'h3FF, 10'h000, 10'h2A5};
    `CHK(feedback0, exp0)
    for (int r = 0; r < 2; r++) begin
      polarity = (r == 1) ? 10'h3FF : 10'h000;
      for (int p = 0; p < 3; p++) begin
        load_one(1'h0, pats[p]);
        load_one(1'h1, ~pats[p]);
      end
    end
  endtask

  // one fuse read; returns just after the answer edge
  task automatic verify(input logic bit_in, input logic prog, input logic want);
    @(posedge clock);
    #1 verify_req = 1'h1;
    fuse_bit = bit_in;
    lock_program = prog;
    @(posedge clock);
    #1 verify_req = 1'h0;
    lock_program = 1'h0;
    `CHK(verify_valid, 1'h1)
    `CHK(verify_data, want)
  endtask

  // lock by program pulse, clear by reset, restore from stored fuse
  task automatic test_lock();
    `CHK(preload_active, 1'h0)
    verify(1'h0, 1'h0, 1'h0);
    verify(1'h1, 1'h0, 1'h1);
    verify(1'h0, 1'h1, 1'h1);
    `CHK(lock_active, 1'h1)
    verify(1'h0, 1'h0, 1'h1);
    resetn = 1'h0; // mid-run reset
    repeat (2) @(posedge clock);
    #1 resetn = 1'h1;
    `CHK(lock_active, 1'h0)
    `CHK(feedback1, {10{REG_RESET_VALUE}})
    verify(1'h0, 1'h0, 1'h0);
    lock_stored = 1'h1;
    verify(1'h0, 1'h0, 1'h1);
    `CHK(lock_active, 1'h1)
  endtask

  // verdict and end of run
  task automatic stop_test();
    if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge clock);
    #1 resetn = 1'h1;
    test_preload();
    test_normal_load();
    test_lock();
    stop_test();
  end

  // watchdog, far beyond the hundred or so cycles the tests need
  initial begin
    #(CLOCK_PERIOD_NS * 2000);
    n_fail++;
    stop_test();
  end
endmodule
`default_nettype wire
